/* File: hdl/fsb_pkg.sv */
// Constants for the streaming buffer controller: register map,
// command codes, reset values and channel ordering fields.
// Assumes a 16-bit register address and 32-bit register data.
package fsb_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_COMMAND = 16'h0000;      // Command word, write only
    localparam logic [15:0] ADDR_HOST_TOTAL = 16'hea60;   // Host buffer total, read/write
    localparam logic [15:0] ADDR_BUF_LEN = 16'hea6a;      // Buffer length in bytes, read/write
    localparam logic [15:0] ADDR_TALLY = 16'hea74;        // Completed buffer tally, read only
    localparam logic [15:0] ADDR_LIMIT = 16'hea7e;        // Auto stop buffer limit, read/write
    localparam logic [15:0] ADDR_RELEASE = 16'hea92;      // Buffer release index, write only
    localparam logic [15:0] ADDR_LEGACY_BASE = 16'heaa0;  // First of the legacy release words
    localparam int LEGACY_COUNT = 16;                     // Legacy words reach buffers 0..15

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [31:0] CMD_STREAM_BEGIN = 32'h0000000c;  // Begin streaming, wait first buffer
    localparam logic [31:0] CMD_NEXT_WAIT = 32'h0000000d;     // Wait for next buffer
    localparam logic [31:0] CMD_STREAM_HALT = 32'h00000014;   // Halt streaming

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [31:0] RST_HOST_TOTAL = 32'h00000002;  // Smallest legal ring
    localparam logic [31:0] RST_BUF_LEN = 32'h00000400;     // One 1024-byte unit
    localparam logic [31:0] RST_LIMIT = 32'h00000000;       // Zero streams without end
    localparam int HOST_TOTAL_MAX = 256;                    // Ring size ceiling
    localparam int HW_BUFFERS = 2;                          // On-board halves, fixed

    // ------------------------------------------------------------
    // Channel enable field and interleave slots
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;             // Analog channels
    localparam int SAMPLE_W = 8;           // Bits per sample
    localparam logic [3:0] CH_ONE = 4'h1;  // Channel 0 only
    localparam logic [3:0] CH_01 = 4'h3;   // Channels 0 and 1
    localparam logic [3:0] CH_02 = 4'h5;   // Channels 0 and 2
    localparam logic [3:0] CH_ALL = 4'hf;  // All four channels

endpackage

/* File: hdl/fsb_interleave.sv */
// Channel interleaver: takes one sample of every enabled channel and
// emits them one byte per handshake in the streaming order.
// Assumes the enable mask is stable while streaming.
`timescale 1ns/1ps
module fsb_interleave (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Channel setup
    input wire logic [3:0] chan_enable,
    // Sample side
    input wire logic [31:0] smp_data,
    input wire logic smp_valid,
    output logic smp_ready,
    // Byte side
    output logic [7:0] byte_data,
    output logic byte_valid,
    input wire logic byte_ready
);

    // ------------------------------------------------------------
    // Ordering helpers
    // ------------------------------------------------------------
    // Slots per sample index for the enable mask
    function automatic logic [2:0] slot_count(input logic [3:0] en);
        case (en)
            fsb_pkg::CH_01,
            fsb_pkg::CH_02: slot_count = 3'h2;
            fsb_pkg::CH_ALL: slot_count = 3'h4;
            default: slot_count = 3'h1;
        endcase
    endfunction

    // Channel carried by a slot; four channels go 0,2,1,3
    function automatic logic [1:0] slot_chan(input logic [3:0] en, input logic [1:0] slot);
        slot_chan = 2'h0;
        case (en)
            fsb_pkg::CH_01: slot_chan = (slot == 2'h0) ? 2'h0 : 2'h1;            // [R10]
            fsb_pkg::CH_02: slot_chan = (slot == 2'h0) ? 2'h0 : 2'h2;            // [R10]
            fsb_pkg::CH_ALL: slot_chan = {slot[0], slot[1]};                     // [R11]
            default: slot_chan = 2'h0;                                           // [R10]
        endcase
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] hold_r;   // Captured sample set
    logic [1:0] slot_r;    // Next slot to emit
    logic full_r;          // Holding a set
    logic [1:0] chan;      // Channel for current slot
    logic last_slot;       // Current slot ends the set

    assign chan = slot_chan(chan_enable, slot_r);
    assign last_slot = ({1'b0, slot_r} + 3'h1) == slot_count(chan_enable);
    assign smp_ready = ~full_r;
    assign byte_valid = full_r;
    // Bits pass unchanged; only the order is touched
    assign byte_data = hold_r[chan*8 +: 8];  // [R12]

    // ------------------------------------------------------------
    // Capture and step through slots
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= 32'h00000000;
            slot_r <= 2'h0;
            full_r <= 1'b0;
        end else if (ce) begin
            if (!full_r && smp_valid) begin
                // New set taken only when the last one is drained
                hold_r <= smp_data;
                slot_r <= 2'h0;
                full_r <= 1'b1;
            end else if (full_r && byte_ready) begin
                if (last_slot) begin
                    full_r <= 1'b0;
                    slot_r <= 2'h0;
                end else begin
                    slot_r <= slot_r + 2'h1;
                end
            end
        end
    end

endmodule

/* File: hdl/fsb_ctrl.sv */
// Streaming buffer controller: fills a ring of host buffers from the
// two on-board halves, counts completions, stops on a limit and runs
// the begin, wait and halt commands.
// Assumes one clock; all inputs come from logic on that clock.
//
// Behaviour
// R1: Tally of completed buffers, readable read-only
// R2: Nonzero limit halts stream when tally reaches
// R3: Zero limit streams forever; host halts explicitly
// R4: Code 12 begins stream, waits first completion
// R5: Code 13 waits for next completed buffer
// R6: Code 20 halts stream, releases pending wait
// R7: Completion pulse ends pending begin or wait
// R8: Host writes index to release a buffer
// R9: Legacy release words, first 16 buffers only
// R10: One channel consecutive, two channels alternate
// R11: Four channels ordered 0, 2, 1, 3
// R12: Sample encoding unchanged from ordinary acquisition
// R13: Exactly two on-board halves used alternately
// R14: Host length is whole multiple of 1024
// R15: Begin command clears tally to zero
`timescale 1ns/1ps
module fsb_ctrl (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Acquisition side
    input wire logic [3:0] chan_enable,
    input wire logic [31:0] smp_data,
    input wire logic smp_valid,
    output logic smp_ready,
    // Host buffer write side
    output logic [7:0] host_wr_data,
    output logic host_wr_valid,
    input wire logic host_wr_ready,
    output logic [7:0] host_wr_buf,
    output logic host_wr_half,
    // Status
    output logic buf_done_irq,
    output logic cmd_waiting,
    output logic streaming
);

    // ------------------------------------------------------------
    // Types and declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSB_IDLE = 2'b00,  // Not streaming
        FSB_RUN = 2'b01    // Streaming
    } fsb_state_e;

    fsb_state_e state_r;         // Streaming state
    fsb_state_e state_nxt;       // Next streaming state
    logic [31:0] total_r;        // Host buffer total
    logic [31:0] len_r;          // Buffer length in bytes
    logic [31:0] limit_r;        // Auto stop limit
    logic [31:0] tally_r;        // Completed buffers this run
    logic [31:0] byte_cnt_r;     // Bytes in current buffer
    logic [7:0] host_idx_r;      // Host buffer being filled
    logic half_r;                // On-board half being filled
    logic [8:0] owed_r;          // Filled, not yet released
    logic pending_r;             // Begin or wait command blocked
    logic [31:0] rdata_r;        // Read data register
    logic rvalid_r;              // Read answer strobe
    logic irq_r;                 // Completion pulse register
    logic [7:0] il_data;         // Interleaver byte
    logic il_valid;              // Interleaver byte valid
    logic il_ready;              // Interleaver byte taken
    logic credit;                // A host buffer is free to fill
    logic xfer;                  // Byte moved to host
    logic done;                  // Byte closes a buffer
    logic wr_cmd;                // Write to command word
    logic cmd_begin;             // Begin command this cycle
    logic cmd_wait;              // Wait command this cycle
    logic cmd_halt;              // Halt command this cycle
    logic release_ok;            // Valid release this cycle
    logic auto_stop;             // Limit reached by this completion
    logic [31:0] tally_inc;      // Tally after this completion

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Index is inside the programmed ring
    function automatic logic idx_in_ring(input logic [31:0] idx, input logic [31:0] total);
        idx_in_ring = idx < total;
    endfunction

    // Step a ring index, wrapping at the total
    function automatic logic [7:0] ring_next(input logic [7:0] idx, input logic [31:0] total);
        if ({24'h000000, idx} + 32'h00000001 >= total) begin
            ring_next = 8'h00;
        end else begin
            ring_next = idx + 8'h01;
        end
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign wr_cmd = ce && reg_wr && (reg_addr == fsb_pkg::ADDR_COMMAND);
    assign cmd_begin = wr_cmd && (reg_wdata == fsb_pkg::CMD_STREAM_BEGIN);   // [R4]
    assign cmd_wait = wr_cmd && (reg_wdata == fsb_pkg::CMD_NEXT_WAIT);       // [R5]
    assign cmd_halt = wr_cmd && (reg_wdata == fsb_pkg::CMD_STREAM_HALT);     // [R6]

    // Release by index, or by one of the sixteen legacy words
    always_comb begin
        release_ok = 1'b0;
        if (ce && reg_wr && owed_r != 9'h000) begin
            if (reg_addr == fsb_pkg::ADDR_RELEASE) begin
                release_ok = idx_in_ring(reg_wdata, total_r);                // [R8]
            end else if (reg_addr >= fsb_pkg::ADDR_LEGACY_BASE &&
                         reg_addr < fsb_pkg::ADDR_LEGACY_BASE + 16'(fsb_pkg::LEGACY_COUNT)) begin
                // Same effect as the index write, buffers 0..15 only
                release_ok = idx_in_ring(32'(reg_addr - fsb_pkg::ADDR_LEGACY_BASE), total_r);  // [R9]
            end
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    // Back-pressure: no byte moves while every host buffer is owed
    assign credit = ({23'h000000, owed_r} < total_r);
    assign host_wr_valid = il_valid && (state_r == FSB_RUN) && credit;
    assign il_ready = host_wr_ready && (state_r == FSB_RUN) && credit;
    assign xfer = ce && host_wr_valid && host_wr_ready;
    // A zero length never completes; software must program it
    assign done = xfer && (byte_cnt_r + 32'h00000001 == len_r);
    assign tally_inc = tally_r + 32'h00000001;
    assign auto_stop = done && (limit_r != 32'h00000000) && (tally_inc >= limit_r);  // [R2] [R3]
    assign host_wr_data = il_data;
    assign host_wr_buf = host_idx_r;
    assign host_wr_half = half_r;

    fsb_interleave u_il (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .chan_enable(chan_enable),
        .smp_data(smp_data),
        .smp_valid(smp_valid),
        .smp_ready(smp_ready),
        .byte_data(il_data),
        .byte_valid(il_valid),
        .byte_ready(il_ready)
    );

    // ------------------------------------------------------------
    // Streaming state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FSB_IDLE: begin
                if (cmd_begin) begin
                    state_nxt = FSB_RUN;                     // [R4]
                end
            end
            FSB_RUN: begin
                if (cmd_begin) begin
                    state_nxt = FSB_RUN;                     // Restart keeps running
                end else if (cmd_halt || auto_stop) begin
                    state_nxt = FSB_IDLE;                    // [R6] [R2]
                end
            end
            default: state_nxt = FSB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= FSB_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Setup registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            total_r <= fsb_pkg::RST_HOST_TOTAL;
            len_r <= fsb_pkg::RST_BUF_LEN;
            limit_r <= fsb_pkg::RST_LIMIT;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                fsb_pkg::ADDR_HOST_TOTAL: total_r <= reg_wdata;
                fsb_pkg::ADDR_BUF_LEN: len_r <= reg_wdata;  // Host keeps 1024 multiple [R14]
                fsb_pkg::ADDR_LIMIT: limit_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Tally, cleared on begin
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tally_r <= 32'h00000000;
        end else if (ce) begin
            if (cmd_begin) begin
                tally_r <= 32'h00000000;                     // [R15]
            end else if (done) begin
                tally_r <= tally_inc;                        // [R1]
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer position: bytes, ring index and on-board half
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_cnt_r <= 32'h00000000;
            host_idx_r <= 8'h00;
            half_r <= 1'b0;
        end else if (ce) begin
            if (cmd_begin) begin
                byte_cnt_r <= 32'h00000000;
                host_idx_r <= 8'h00;
                half_r <= 1'b0;
            end else if (done) begin
                byte_cnt_r <= 32'h00000000;
                host_idx_r <= ring_next(host_idx_r, total_r);
                // Only two halves, so a toggle is the whole rotation
                half_r <= ~half_r;                           // [R13]
            end else if (xfer) begin
                byte_cnt_r <= byte_cnt_r + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Owed buffers: filled and not yet handed back
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owed_r <= 9'h000;
        end else if (ce) begin
            if (cmd_begin) begin
                owed_r <= 9'h000;
            end else if (done && !release_ok) begin
                owed_r <= owed_r + 9'h001;
            end else if (release_ok && !done) begin
                owed_r <= owed_r - 9'h001;                   // [R8] [R9]
            end
        end
    end

    // ------------------------------------------------------------
    // Completion pulse and blocked command
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= done;                                   // [R7]
        end
    end

    // A command in the completion cycle waits for the following one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (ce) begin
            if (cmd_begin || (cmd_wait && state_r == FSB_RUN)) begin
                pending_r <= 1'b1;                           // [R4] [R5]
            end else if (cmd_halt) begin
                pending_r <= 1'b0;                           // [R6]
            end else if (irq_r) begin
                pending_r <= 1'b0;                           // [R7]
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads, answered one cycle later
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h00000000;
            rvalid_r <= 1'b0;
        end else if (ce) begin
            rvalid_r <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    fsb_pkg::ADDR_HOST_TOTAL: rdata_r <= total_r;
                    fsb_pkg::ADDR_BUF_LEN: rdata_r <= len_r;
                    fsb_pkg::ADDR_TALLY: rdata_r <= tally_r;  // [R1]
                    fsb_pkg::ADDR_LIMIT: rdata_r <= limit_r;
                    default: rdata_r <= 32'h00000000;          // Write-only and unmapped read zero
                endcase
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign buf_done_irq = irq_r;
    assign cmd_waiting = pending_r;
    assign streaming = (state_r == FSB_RUN);

endmodule

/* File: bench/fsb_ctrl_assertions.sv */
// Port checker for the streaming buffer controller.
// Assumes a bind onto fsb_ctrl with every pin by name.
`timescale 1ns/1ps
module fsb_ctrl_chk (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    // Stream and status
    input wire logic host_wr_valid,
    input wire logic host_wr_half,
    input wire logic buf_done_irq,
    input wire logic cmd_waiting,
    input wire logic streaming
);
    // ------------------------------
    // Command decode
    // ------------------------------
    logic cmd_wr; // Write into the command word
    assign cmd_wr = ce && reg_wr && reg_addr == fsb_pkg::ADDR_COMMAND;

    // ------------------------------
    // Properties
    // ------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    read_answer_a: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    stray_answer_a: assert property (!(ce && reg_rd) |=> !reg_rvalid)
        else $error("read answer without read");
    begin_wait_a: assert property (cmd_wr && reg_wdata == fsb_pkg::CMD_STREAM_BEGIN |=> streaming && cmd_waiting)
        else $error("begin did not start and block");
    next_wait_a: assert property (cmd_wr && reg_wdata == fsb_pkg::CMD_NEXT_WAIT && streaming && !buf_done_irq
        |=> cmd_waiting)
        else $error("wait command did not block");
    halt_clear_a: assert property (cmd_wr && reg_wdata == fsb_pkg::CMD_STREAM_HALT |=> !streaming && !cmd_waiting)
        else $error("halt left stream or wait active");
    wait_end_a: assert property (buf_done_irq && !cmd_wr |=> !cmd_waiting)
        else $error("completion did not end pending wait");
    irq_single_a: assert property (buf_done_irq |=> !buf_done_irq)
        else $error("completion pulse too long");
    half_flip_a: assert property (buf_done_irq |-> host_wr_half != $past(host_wr_half))
        else $error("on-board half did not alternate");
    idle_quiet_a: assert property (!streaming |-> !host_wr_valid)
        else $error("byte offered while idle");
endmodule

bind fsb_ctrl fsb_ctrl_chk u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
    .host_wr_valid(host_wr_valid), .host_wr_half(host_wr_half),
    .buf_done_irq(buf_done_irq), .cmd_waiting(cmd_waiting), .streaming(streaming)
);

/* File: bench/fsb_host_model.sv */
// Host memory model: takes bytes and keeps them in arrival order.
// Assumes the bench reads the queue after each run.
`timescale 1ns/1ps
module fsb_host_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Byte stream
    input wire logic [7:0] data,
    input wire logic valid,
    output logic ready
);
    // ------------------------------
    // Capture
    // ------------------------------
    logic [7:0] q[$]; // Bytes as written into host memory
    logic [1:0] cnt_r = 2'h0; // Pacing phase
    // Slow mode takes one byte in four, so the sender must hold
    assign ready = !slow || cnt_r == 2'h3;
    always @(posedge clk) begin
        cnt_r <= cnt_r + 2'h1;
        if (valid && ready) begin
            q.push_back(data);
        end
    end
endmodule

/* File: bench/fsb_ctrl_tb_top.sv */
// Self-checking bench for the streaming buffer controller.
// Assumes the checker and host model files are compiled first.
`timescale 1ns/1ps
module fsb_ctrl_tb_top;
    // ------------------------------
    // Signals
    // ------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, smp_data;
    logic [3:0] chan_enable = fsb_pkg::CH_ONE;
    logic reg_rvalid, smp_valid, smp_ready, host_wr_valid, host_wr_ready, host_wr_half;
    logic [7:0] host_wr_data, host_wr_buf;
    logic buf_done_irq, cmd_waiting, streaming;
    logic slow = 1'b0; // Host stalls when set
    logic [7:0] set_idx = 8'h00; // Sample set number
    int n_errors = 0;
    int check_count = 0;
    int irq_seen = 0;
    int irq_base = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    // Channel n carries {set, n}, so each byte names its origin
    assign smp_data = {set_idx[5:0], 2'h3, set_idx[5:0], 2'h2, set_idx[5:0], 2'h1, set_idx[5:0], 2'h0};
    // Offer samples only while streaming, so no set is stranded
    assign smp_valid = streaming;

    // ------------------------------
    // Instances
    // ------------------------------
    fsb_ctrl u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .chan_enable(chan_enable), .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .host_wr_data(host_wr_data), .host_wr_valid(host_wr_valid), .host_wr_ready(host_wr_ready),
        .host_wr_buf(host_wr_buf), .host_wr_half(host_wr_half), .buf_done_irq(buf_done_irq),
        .cmd_waiting(cmd_waiting), .streaming(streaming));
    fsb_host_model u_host (.clk(clk), .slow(slow), .data(host_wr_data), .valid(host_wr_valid),
        .ready(host_wr_ready));

    // Set counter, completion counter and hang guard
    always @(posedge clk) begin
        if (smp_valid && smp_ready) begin
            set_idx <= set_idx + 8'h01;
        end
        if (buf_done_irq === 1'b1) begin
            irq_seen <= irq_seen + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk(32'(reg_rvalid), 32'h1);
        chk(reg_rdata, exp);
        tick();
    endtask

    // Wait, bounded, for n completions since the last begin
    task automatic wait_irqs(input int n);
        int k;
        k = 0;
        while (irq_seen - irq_base < n && k < 20000) begin
            tick();
            k++;
        end
        chk(32'(irq_seen - irq_base), 32'(n));
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    // Reset values, write-only and unmapped reads
    task automatic reset_regs();
        rd_chk(fsb_pkg::ADDR_LIMIT, 32'h0);
        rd_chk(fsb_pkg::ADDR_TALLY, 32'h0);
        rd_chk(fsb_pkg::ADDR_HOST_TOTAL, 32'h2);
        rd_chk(fsb_pkg::ADDR_BUF_LEN, 32'h400);
        rd_chk(fsb_pkg::ADDR_COMMAND, 32'h0);
        rd_chk(16'h1234, 32'h0);
    endtask

    // One-buffer run per channel mode; ord holds the channel of each slot
    task automatic run_mode(input logic [3:0] m, input logic [7:0] ord, input int nch);
        int k;
        chan_enable = m;
        slow = nch > 1;
        u_host.q.delete();
        wr(fsb_pkg::ADDR_LIMIT, 32'h1);
        irq_base = irq_seen;
        wr(fsb_pkg::ADDR_COMMAND, fsb_pkg::CMD_STREAM_BEGIN);
        chk(32'(cmd_waiting), 32'h1);
        rd_chk(fsb_pkg::ADDR_TALLY, 32'h0);
        wait_irqs(1);
        chk(32'(streaming), 32'h0);
        tick();
        chk(32'(cmd_waiting), 32'h0);
        rd_chk(fsb_pkg::ADDR_TALLY, 32'h1);
        chk(32'(u_host.q.size()), 32'h400);
        for (k = 0; k < 1024; k++) begin
            chk(u_host.q[k], {6'(u_host.q[0][7:2] + k / nch), ord[2 * (k % nch) +: 2]});
        end
    endtask

    // Endless run that stalls on the ring, legacy and indexed releases
    task automatic ring_stall();
        chan_enable = fsb_pkg::CH_ALL;
        slow = 1'b0;
        wr(fsb_pkg::ADDR_LIMIT, 32'h0);
        irq_base = irq_seen;
        wr(fsb_pkg::ADDR_COMMAND, fsb_pkg::CMD_STREAM_BEGIN);
        wait_irqs(2);
        repeat (20) tick();
        chk(32'(host_wr_valid), 32'h0);
        chk(32'(streaming), 32'h1);
        chk(32'(host_wr_buf), 32'h0);
        chk(32'(host_wr_half), 32'h0);
        wr(fsb_pkg::ADDR_LEGACY_BASE, 32'h0);
        wait_irqs(3);
        wr(fsb_pkg::ADDR_RELEASE, 32'h2);
        wr(fsb_pkg::ADDR_COMMAND, fsb_pkg::CMD_NEXT_WAIT);
        repeat (50) tick();
        chk(32'(cmd_waiting), 32'h1);
        chk(32'(irq_seen - irq_base), 32'h3);
        wr(fsb_pkg::ADDR_RELEASE, 32'h1);
        wait_irqs(4);
        tick();
        chk(32'(cmd_waiting), 32'h0);
        wr(fsb_pkg::ADDR_COMMAND, fsb_pkg::CMD_STREAM_HALT);
        chk(32'(streaming), 32'h0);
        wr(fsb_pkg::ADDR_TALLY, 32'h55);
        rd_chk(fsb_pkg::ADDR_TALLY, 32'h4);
    endtask

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick();
        reset_regs();
        run_mode(fsb_pkg::CH_ONE, 8'h00, 1);
        run_mode(fsb_pkg::CH_01, 8'h04, 2);
        run_mode(fsb_pkg::CH_02, 8'h08, 2);
        run_mode(fsb_pkg::CH_ALL, 8'hd8, 4);
        ring_stall();
        tally_and_finish();
    end
endmodule
